// file: core/nam_alu.sv
// Behaviour
// - Four-bit accumulator; operands from accumulator, any nibble 0x00-0xFF, or literal.
// - XOR, AND, OR into accumulator update zero only, carry kept.
// - Rotates through carry update carry and zero; plain accumulator rotates touch no flag.
// - Add is accumulator plus operand plus carry; carry set above 0xF.
// - Subtract borrows the inverted carry; carry cleared only on negative result.
// - Zero follows flagged results; load from memory sets zero; other moves don't.
// - Set-carry forces one, clear-carry forces zero, nothing else.
// - Short register moves use three address bits, reaching registers 0x0-0x7.
// - Short RAM addresses are five bits landing in 0x20-0x3F, page applies.
// - Bit set/clear and short moves hit 0x20-0x3F in one cycle.
// - Conditional jumps load bank and 16-bit address on carry, zero or bit.
// - Compare skips on greater, less, unequal, or accumulator bit low or high.
// - A skip turns the next instruction into a no-operation.
// - Play skips test the selected channel; one more fires when all idle.
// - In-bank jump and call join the bank register at 0x10 and address.
// - Pointer jump and call load the full 21-bit pointer, bank ignored.
// - Execution starts at program address 0x400 after reset.
// - Vectors sit at 0x000-0x00F, reserved system region at 0x010-0x3FF.
// - Two RAM pages of 224 nibbles, page zero after reset.
// - Addresses 0x00-0x1F hit shared registers; RAM is 0x20-0xFF per page.
// - Indexed access takes page from pointer nibble one, address from nibble zero.
`timescale 1ns/100ps
`default_nettype none
module nam_alu
   import nam_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // Instruction from sequencer
   input  wire logic        opValid,
   input  wire nam_op_t     opCode,
   input  wire logic [7:0]  memAddr,
   input  wire logic [2:0]  regAddr,
   input  wire logic [3:0]  literal,
   input  wire logic [1:0]  bitSel,
   input  wire logic [15:0] jumpAddr,
   // Voice channel status
   input  wire logic [7:0]  headPlay,
   input  wire logic [7:0]  chanPlay,
   // External function registers
   output logic      [4:0]  sfrRdAddr,
   input  wire logic [3:0]  sfrRdData,
   output logic             sfrWr,
   output logic      [4:0]  sfrWrAddr,
   output logic      [3:0]  sfrWrData,
   // Program counter control
   output logic             pcLoad,
   output logic             pcPush,
   output logic      [20:0] pcTarget,
   output logic             reservedHit,
   output logic             skipNext,
   // Visible state
   output logic      [3:0]  accum,
   output logic             carry,
   output logic             zero,
   output logic             ramPage,
   output logic      [3:0]  bankSel,
   output logic      [2:0]  chanSel
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [8:0] ramIdx(input logic pg, input logic [7:0] a);
      ramIdx = {1'b0, a} - {1'b0, RAM_BASE} + (pg ? PAGE_NIBBLES : 9'h000);
   endfunction : ramIdx

   function automatic logic [3:0] rdNib(input nam_state_t t, input logic [7:0] a,
                                        input logic [3:0] ext);
      rdNib = ext;
      if (a < RAM_BASE) begin
         if (a[4:0] <= ADDR_PTR_LAST)
            rdNib = t.ptr[a[2:0]];
         else if (a[4:0] == ADDR_BANK)
            rdNib = t.bank;
         else if (a[4:0] == ADDR_CHAN)
            rdNib = {1'b0, t.chan};
         else if (a[4:0] == ADDR_INDEX)
            rdNib = t.ram[ramIdx(t.ptr[1][0], {INDEX_HI, t.ptr[0]})];
      end else begin
         rdNib = t.ram[ramIdx(t.page, a)];
      end
   endfunction : rdNib

   // ****************************************
   // State
   // ****************************************
   nam_state_t  st_r;
   nam_state_t  st_nxt;
   logic        live, shortRam, litOp, wrEn, skipHit, jumpHit;
   logic [7:0]  memA, regA, rdA, wrA;
   logic [3:0]  extRd, rdData, opnd, wrData;
   logic [4:0]  sum5, diff5, incDec;
   logic [20:0] bankTarget, ptrTarget;

   assign live     = opValid && !st_r.skip;
   assign shortRam = opCode inside {OP_REG_TO_RAM, OP_RAM_TO_REG, OP_BIT_CLEAR, OP_BIT_SET};
   assign litOp    = opCode inside {OP_XOR_LIT, OP_AND_LIT, OP_OR_LIT, OP_ADD_LIT, OP_SUB_LIT};
   assign memA     = shortRam ? {SHORT_RAM_HI, memAddr[4:0]} : memAddr;
   assign regA     = {SHORT_REG_HI, regAddr};
   assign rdA      = (opCode == OP_REG_TO_RAM) ? regA : memA;
   assign wrA      = (opCode inside {OP_RAM_TO_REG, OP_LIT_TO_REG}) ? regA : memA;
   assign sfrRdAddr = rdA[4:0];
   assign extRd    = (st_r.sfrWr && st_r.sfrWrAddr == rdA[4:0]) ? st_r.sfrWrData : sfrRdData;
   assign rdData   = rdNib(st_r, rdA, extRd);
   assign opnd     = litOp ? literal : rdData;
   assign sum5     = {1'b0, st_r.acc} + {1'b0, opnd} + {4'h0, st_r.carry};
   assign diff5    = {1'b0, st_r.acc} - {1'b0, opnd} - {4'h0, ~st_r.carry};
   assign bankTarget = {1'b0, st_r.bank, jumpAddr};
   assign ptrTarget  = {st_r.ptr[5][0], st_r.ptr[4:0]};

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_nxt        = st_r;
      st_nxt.pcLoad = 1'b0;
      st_nxt.pcPush = 1'b0;
      st_nxt.sfrWr  = 1'b0;
      wrEn    = 1'b0;
      wrData  = rdData;
      skipHit = 1'b0;
      jumpHit = 1'b0;
      incDec  = 5'h00;
      if (opValid)
         st_nxt.skip = 1'b0;
      if (live) begin
         unique case (opCode)
            OP_XOR_MEM, OP_XOR_LIT: st_nxt.acc = st_r.acc ^ opnd;
            OP_AND_MEM, OP_AND_LIT: st_nxt.acc = st_r.acc & opnd;
            OP_OR_MEM, OP_OR_LIT:   st_nxt.acc = st_r.acc | opnd;
            OP_ROT_R_MEM_C: begin
               wrEn = 1'b1;
               {wrData, st_nxt.carry} = {st_r.carry, rdData};
            end
            OP_ROT_L_MEM_C: begin
               wrEn = 1'b1;
               {st_nxt.carry, wrData} = {rdData, st_r.carry};
            end
            OP_ROT_R_ACC_C: {st_nxt.acc, st_nxt.carry} = {st_r.carry, st_r.acc};
            OP_ROT_L_ACC_C: {st_nxt.carry, st_nxt.acc} = {st_r.acc, st_r.carry};
            OP_ROT_R_ACC:   st_nxt.acc = {st_r.acc[0], st_r.acc[3:1]};
            OP_ROT_L_ACC:   st_nxt.acc = {st_r.acc[2:0], st_r.acc[3]};
            OP_INC_MEM, OP_DEC_MEM: begin
               incDec = {1'b0, rdData} + ((opCode == OP_INC_MEM) ? 5'h01 : 5'h1F);
               wrEn = 1'b1;
               wrData = incDec[3:0];
               st_nxt.carry = (opCode == OP_INC_MEM) ? incDec[4] : ~incDec[4];
            end
            OP_INC_ACC, OP_DEC_ACC: begin
               incDec = {1'b0, st_r.acc} + ((opCode == OP_INC_ACC) ? 5'h01 : 5'h1F);
               st_nxt.acc = incDec[3:0];
               st_nxt.carry = (opCode == OP_INC_ACC) ? incDec[4] : ~incDec[4];
            end
            OP_ADD_MEM, OP_ADD_LIT: {st_nxt.carry, st_nxt.acc} = sum5;
            OP_SUB_MEM, OP_SUB_LIT: {st_nxt.carry, st_nxt.acc} = {~diff5[4], diff5[3:0]};
            OP_NEGATE_ACC: st_nxt.acc = 4'h0 - st_r.acc;
            OP_STORE_ACC: begin
               wrEn = 1'b1;
               wrData = st_r.acc;
            end
            OP_LOAD_ACC:   st_nxt.acc = rdData;
            OP_REG_TO_RAM, OP_RAM_TO_REG: wrEn = 1'b1;
            OP_LIT_TO_REG: begin
               wrEn = 1'b1;
               wrData = literal;
            end
            OP_LIT_TO_ACC: st_nxt.acc = literal;
            OP_BIT_CLEAR, OP_BIT_SET: begin
               wrEn = 1'b1;
               wrData[bitSel] = opCode == OP_BIT_SET;
            end
            OP_CARRY_ONE:  st_nxt.carry = 1'b1;
            OP_CARRY_ZERO: st_nxt.carry = 1'b0;
            OP_JUMP_C_LOW:  jumpHit = !st_r.carry;
            OP_JUMP_C_HIGH: jumpHit = st_r.carry;
            OP_JUMP_Z_LOW:  jumpHit = !st_r.zero;
            OP_JUMP_Z_HIGH: jumpHit = st_r.zero;
            OP_JUMP_BIT:    jumpHit = st_r.acc[bitSel];
            OP_SKIP_GT:       skipHit = st_r.acc > literal;
            OP_SKIP_LT:       skipHit = st_r.acc < literal;
            OP_SKIP_NE:       skipHit = st_r.acc != literal;
            OP_SKIP_BIT_LOW:  skipHit = !st_r.acc[bitSel];
            OP_SKIP_BIT_HIGH: skipHit = st_r.acc[bitSel];
            OP_SKIP_HEAD_IDLE:   skipHit = !headPlay[st_r.chan];
            OP_SKIP_HEAD_ACTIVE: skipHit = headPlay[st_r.chan];
            OP_SKIP_CHAN_IDLE:   skipHit = !chanPlay[st_r.chan];
            OP_SKIP_CHAN_ACTIVE: skipHit = chanPlay[st_r.chan];
            OP_SKIP_ALL_IDLE:    skipHit = chanPlay == 8'h00;
            OP_JUMP_BANK, OP_CALL_BANK: begin
               jumpHit = 1'b1;
               st_nxt.pcPush = opCode == OP_CALL_BANK;
            end
            OP_JUMP_PTR, OP_CALL_PTR: begin
               st_nxt.pcLoad = 1'b1;
               st_nxt.pcPush = opCode == OP_CALL_PTR;
               st_nxt.pcTarget = ptrTarget;
               st_nxt.reservedHit = ptrTarget <= RESERVED_HI;
            end
            OP_PAGE_ZERO: st_nxt.page = 1'b0;
            OP_PAGE_ONE:  st_nxt.page = 1'b1;
            OP_NONE: ;
         endcase
         if (jumpHit) begin
            st_nxt.pcLoad = 1'b1;
            st_nxt.pcTarget = bankTarget;
            st_nxt.reservedHit = bankTarget <= RESERVED_HI;
         end
         st_nxt.skip = skipHit;
         if (opCode inside {OP_XOR_MEM, OP_AND_MEM, OP_OR_MEM, OP_XOR_LIT, OP_AND_LIT,
                            OP_OR_LIT, OP_ROT_R_ACC_C, OP_ROT_L_ACC_C, OP_INC_ACC,
                            OP_DEC_ACC, OP_ADD_MEM, OP_ADD_LIT, OP_SUB_MEM,
                            OP_SUB_LIT, OP_LOAD_ACC})
            st_nxt.zero = st_nxt.acc == 4'h0;
         if (opCode inside {OP_ROT_R_MEM_C, OP_ROT_L_MEM_C, OP_INC_MEM, OP_DEC_MEM})
            st_nxt.zero = wrData == 4'h0;
         // write into register window or page
         if (wrEn) begin
            if (wrA >= RAM_BASE)
               st_nxt.ram[ramIdx(st_r.page, wrA)] = wrData;
            else if (wrA[4:0] <= ADDR_PTR_LAST)
               st_nxt.ptr[wrA[2:0]] = wrData;
            else if (wrA[4:0] == ADDR_BANK)
               st_nxt.bank = wrData;
            else if (wrA[4:0] == ADDR_CHAN)
               st_nxt.chan = wrData[2:0];
            else if (wrA[4:0] == ADDR_INDEX)
               st_nxt.ram[ramIdx(st_r.ptr[1][0], {INDEX_HI, st_r.ptr[0]})] = wrData;
            else begin
               st_nxt.sfrWr = 1'b1;
               st_nxt.sfrWrAddr = wrA[4:0];
               st_nxt.sfrWrData = wrData;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.bank <= BANK_RESET;
         st_r.page <= PAGE_RESET;
         st_r.pcLoad <= 1'b1;
         st_r.pcTarget <= RESET_VECTOR;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign accum       = st_r.acc;
   assign carry       = st_r.carry;
   assign zero        = st_r.zero;
   assign ramPage     = st_r.page;
   assign bankSel     = st_r.bank;
   assign chanSel     = st_r.chan;
   assign skipNext    = st_r.skip;
   assign pcLoad      = st_r.pcLoad;
   assign pcPush      = st_r.pcPush;
   assign pcTarget    = st_r.pcTarget;
   assign reservedHit = st_r.reservedHit;
   assign sfrWr       = st_r.sfrWr;
   assign sfrWrAddr   = st_r.sfrWrAddr;
   assign sfrWrData   = st_r.sfrWrData;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   logicKeepsCarry_a: assert property (
      live && opCode inside {OP_XOR_LIT, OP_AND_LIT, OP_OR_LIT} |=>
      carry == $past(carry) && zero == (accum == 4'h0))
      else $error("logic op disturbed carry or zero");
   addCarry_a: assert property (
      live && opCode == OP_ADD_LIT |=>
      {carry, accum} == {1'b0, $past(accum)} + {1'b0, $past(literal)} + {4'h0, $past(carry)})
      else $error("add result or carry wrong");
   subBorrow_a: assert property (
      live && opCode == OP_SUB_LIT |=>
      carry == ({1'b0, $past(accum)} >= {1'b0, $past(literal)} + {4'h0, !$past(carry)}))
      else $error("subtract carry wrong");
   plainRotate_a: assert property (
      live && opCode inside {OP_ROT_R_ACC, OP_ROT_L_ACC} |=> $stable(carry) && $stable(zero))
      else $error("plain rotate changed a flag");
   carryForce_a: assert property (
      live && opCode == OP_CARRY_ONE |=> carry && $stable(accum) && $stable(zero))
      else $error("set carry misbehaved");
   skipVoid_a: assert property (
      live && opCode == OP_SKIP_NE && accum != literal ##1 opValid |=>
      $stable(accum) && $stable(carry) && !pcLoad && !sfrWr)
      else $error("skipped instruction took effect");
   bankJump_a: assert property (
      live && opCode == OP_JUMP_BANK |=>
      pcLoad && pcTarget == {1'b0, $past(bankSel), $past(jumpAddr)})
      else $error("in-bank jump target wrong");
   pointerJump_a: assert property (
      live && opCode == OP_JUMP_PTR |=> pcLoad && !pcPush && pcTarget == $past(ptrTarget))
      else $error("pointer jump target wrong");

endmodule : nam_alu
`default_nettype wire

// file: core/nam_pkg.sv
package nam_pkg;

   // ****************************************
   // Memory map
   // ****************************************
   localparam logic [20:0] RESET_VECTOR  = 21'h000400;
   localparam logic [20:0] VECTOR_FIRST  = 21'h000000;
   localparam logic [20:0] VECTOR_LAST   = 21'h00000F;
   localparam logic [20:0] RESERVED_LO   = 21'h000010;
   localparam logic [20:0] RESERVED_HI   = 21'h0003FF;
   localparam logic [7:0]  RAM_BASE      = 8'h20;
   localparam logic [2:0]  SHORT_RAM_HI  = 3'h1;
   localparam logic [4:0]  SHORT_REG_HI  = 5'h00;
   localparam logic [8:0]  PAGE_NIBBLES  = 9'h0E0;
   localparam int          RAM_NIBBLES   = 448;
   localparam logic [3:0]  INDEX_HI      = 4'h2;

   // ****************************************
   // Register offsets and reset values
   // ****************************************
   localparam logic [4:0]  ADDR_PTR_LAST = 5'h05;
   localparam logic [4:0]  ADDR_BANK     = 5'h10;
   localparam logic [4:0]  ADDR_CHAN     = 5'h11;
   localparam logic [4:0]  ADDR_INDEX    = 5'h12;
   localparam logic [3:0]  BANK_RESET    = 4'h0;
   localparam logic        PAGE_RESET    = 1'b0;

   // ****************************************
   // Operations
   // ****************************************
   typedef enum logic [5:0] {
      OP_NONE, OP_XOR_MEM, OP_AND_MEM, OP_OR_MEM, OP_XOR_LIT, OP_AND_LIT, OP_OR_LIT,
      OP_ROT_R_MEM_C, OP_ROT_L_MEM_C, OP_ROT_R_ACC_C, OP_ROT_L_ACC_C,
      OP_ROT_R_ACC, OP_ROT_L_ACC, OP_INC_MEM, OP_DEC_MEM, OP_ADD_MEM, OP_ADD_LIT,
      OP_SUB_MEM, OP_SUB_LIT, OP_INC_ACC, OP_DEC_ACC, OP_NEGATE_ACC,
      OP_STORE_ACC, OP_LOAD_ACC, OP_REG_TO_RAM, OP_RAM_TO_REG, OP_LIT_TO_REG,
      OP_LIT_TO_ACC, OP_BIT_CLEAR, OP_BIT_SET, OP_CARRY_ONE, OP_CARRY_ZERO,
      OP_JUMP_C_LOW, OP_JUMP_C_HIGH, OP_JUMP_Z_LOW, OP_JUMP_Z_HIGH, OP_JUMP_BIT,
      OP_SKIP_GT, OP_SKIP_LT, OP_SKIP_NE, OP_SKIP_BIT_LOW, OP_SKIP_BIT_HIGH,
      OP_SKIP_HEAD_IDLE, OP_SKIP_HEAD_ACTIVE, OP_SKIP_CHAN_IDLE, OP_SKIP_CHAN_ACTIVE,
      OP_SKIP_ALL_IDLE, OP_JUMP_BANK, OP_CALL_BANK, OP_JUMP_PTR, OP_CALL_PTR,
      OP_PAGE_ZERO, OP_PAGE_ONE
   } nam_op_t;

   typedef struct packed {
      logic [RAM_NIBBLES-1:0][3:0] ram;
      logic [5:0][3:0]             ptr;
      logic [3:0]                  acc;
      logic                        carry;
      logic                        zero;
      logic                        page;
      logic [3:0]                  bank;
      logic [2:0]                  chan;
      logic                        skip;
      logic                        pcLoad;
      logic                        pcPush;
      logic [20:0]                 pcTarget;
      logic                        reservedHit;
      logic                        sfrWr;
      logic [4:0]                  sfrWrAddr;
      logic [3:0]                  sfrWrData;
   } nam_state_t;

endpackage : nam_pkg

// file: verif/nam_sfr_model.sv
`timescale 1ns/100ps
`default_nettype none
module nam_sfr_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [4:0] sfrRdAddr,
   output logic      [3:0] sfrRdData,
   input  wire logic       sfrWr,
   input  wire logic [4:0] sfrWrAddr,
   input  wire logic [3:0] sfrWrData
);
   // ******
   // External function registers
   // ******
   logic [31:0][3:0] regs_r;

   // Same-cycle read
   assign sfrRdData = regs_r[sfrRdAddr];

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         regs_r <= {16{8'h96}};
      end else if (sfrWr) begin
         regs_r[sfrWrAddr] <= sfrWrData;
      end
   end
endmodule : nam_sfr_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
   import nam_pkg::*;
;
   // ******
   // Signals
   // ******
   logic        clock, rst_b, opValid, sfrWr, pcLoad, pcPush, reservedHit;
   logic        skipNext, carry, zero, ramPage;
   nam_op_t     opCode;
   logic [1:0]  bitSel;
   logic [2:0]  regAddr, chanSel;
   logic [3:0]  literal, sfrRdData, sfrWrData, accum, bankSel;
   logic [4:0]  sfrRdAddr, sfrWrAddr;
   logic [7:0]  memAddr, headPlay, chanPlay;
   logic [15:0] jumpAddr;
   logic [20:0] pcTarget;
   int          mismatches, checksDone;

   // ******
   // Design and partner
   // ******
   nam_alu i_dut (
      .clock(clock), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
      .memAddr(memAddr), .regAddr(regAddr), .literal(literal), .bitSel(bitSel),
      .jumpAddr(jumpAddr), .headPlay(headPlay), .chanPlay(chanPlay),
      .sfrRdAddr(sfrRdAddr), .sfrRdData(sfrRdData), .sfrWr(sfrWr),
      .sfrWrAddr(sfrWrAddr), .sfrWrData(sfrWrData), .pcLoad(pcLoad),
      .pcPush(pcPush), .pcTarget(pcTarget), .reservedHit(reservedHit),
      .skipNext(skipNext), .accum(accum), .carry(carry), .zero(zero),
      .ramPage(ramPage), .bankSel(bankSel), .chanSel(chanSel));

   nam_sfr_model i_sfr (
      .clock(clock), .rst_b(rst_b), .sfrRdAddr(sfrRdAddr), .sfrRdData(sfrRdData),
      .sfrWr(sfrWr), .sfrWrAddr(sfrWrAddr), .sfrWrData(sfrWrData));

   // ******
   // Tasks
   // ******
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(logic [20:0] seen, logic [20:0] exp);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   // One slot from a falling edge; ex holds {accum, carry, zero}
   task automatic step(nam_op_t o, logic [7:0] m, logic [3:0] l, logic [5:0] ex);
      opValid = 1'b1;
      opCode  = o;
      memAddr = m;
      regAddr = m[2:0];
      literal = l;
      bitSel  = l[1:0];
      @(negedge clock);
      chk(21'(accum), 21'(ex[5:2]));
      chk(21'(carry), 21'(ex[1]));
      chk(21'(zero), 21'(ex[0]));
   endtask : step

   task automatic jp(nam_op_t o, logic [3:0] l, logic [5:0] ex, logic e, logic [20:0] t);
      step(o, 8'h00, l, ex);
      chk(21'(pcLoad), 21'(e));
      if (e) begin
         chk(pcTarget, t);
      end
   endtask : jp

   task automatic sk(nam_op_t o, logic [3:0] l, logic [5:0] ex, logic e);
      step(o, 8'h00, l, ex);
      chk(21'(skipNext), 21'(e));
      step(OP_JUMP_BANK, 8'h00, 4'h0, ex);
      chk(21'(pcLoad), 21'(!e));
      chk(21'(skipNext), 21'h0);
   endtask : sk

   // ******
   // Clock, watchdog, sequence
   // ******
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      end_sim();
   end

   initial begin
      logic [3:0] pv [6];
      pv = '{4'h5, 4'h1, 4'h3, 4'h4, 4'h5, 4'h1};
      rst_b = 1'b0;
      opValid = 1'b0;
      opCode = OP_NONE;
      memAddr = 8'h00;
      regAddr = 3'h0;
      literal = 4'h0;
      bitSel = 2'h0;
      jumpAddr = 16'h1234;
      headPlay = 8'h08;
      chanPlay = 8'h00;
      repeat (3) @(negedge clock);
      chk(21'(pcLoad), 21'h1);
      chk(pcTarget, 21'h000400);
      chk(21'(ramPage), 21'h0);
      chk(21'(bankSel), 21'(BANK_RESET));
      rst_b = 1'b1;
      @(negedge clock);
      chk(21'(pcLoad), 21'h0);
      step(OP_CARRY_ONE, 8'h00, 4'h0, 6'h02);
      step(OP_CARRY_ZERO, 8'h00, 4'h0, 6'h00);
      step(OP_LIT_TO_ACC, 8'h00, 4'hE, 6'h38);
      step(OP_ADD_LIT, 8'h00, 4'h1, 6'h3C);
      step(OP_ADD_LIT, 8'h00, 4'h1, 6'h03);
      step(OP_ADD_LIT, 8'h00, 4'h0, 6'h04);
      step(OP_CARRY_ONE, 8'h00, 4'h0, 6'h06);
      step(OP_SUB_LIT, 8'h00, 4'h1, 6'h03);
      step(OP_SUB_LIT, 8'h00, 4'h1, 6'h3C);
      step(OP_SUB_LIT, 8'h00, 4'h0, 6'h3A);
      step(OP_XOR_LIT, 8'h00, 4'hE, 6'h03);
      step(OP_OR_LIT, 8'h00, 4'h9, 6'h26);
      step(OP_AND_LIT, 8'h00, 4'h3, 6'h06);
      step(OP_ROT_L_ACC, 8'h00, 4'h0, 6'h0A);
      step(OP_ROT_R_ACC_C, 8'h00, 4'h0, 6'h24);
      step(OP_ROT_L_ACC_C, 8'h00, 4'h0, 6'h0A);
      step(OP_ROT_R_ACC, 8'h00, 4'h0, 6'h06);
      step(OP_DEC_ACC, 8'h00, 4'h0, 6'h03);
      step(OP_DEC_ACC, 8'h00, 4'h0, 6'h3C);
      step(OP_INC_ACC, 8'h00, 4'h0, 6'h03);
      step(OP_LIT_TO_ACC, 8'h00, 4'h3, 6'h0F);
      step(OP_NEGATE_ACC, 8'h00, 4'h0, 6'h37);
      step(OP_CARRY_ZERO, 8'h00, 4'h0, 6'h35);
      jp(OP_JUMP_C_LOW, 4'h0, 6'h35, 1'b1, 21'h001234);
      jp(OP_JUMP_C_HIGH, 4'h0, 6'h35, 1'b0, 21'h0);
      jp(OP_JUMP_Z_LOW, 4'h0, 6'h35, 1'b0, 21'h0);
      jp(OP_JUMP_Z_HIGH, 4'h0, 6'h35, 1'b1, 21'h001234);
      jp(OP_JUMP_BIT, 4'h0, 6'h35, 1'b1, 21'h001234);
      jp(OP_JUMP_BIT, 4'h1, 6'h35, 1'b0, 21'h0);
      step(OP_STORE_ACC, 8'h40, 4'h0, 6'h35);
      step(OP_PAGE_ONE, 8'h00, 4'h0, 6'h35);
      chk(21'(ramPage), 21'h1);
      step(OP_LIT_TO_ACC, 8'h00, 4'h5, 6'h15);
      step(OP_STORE_ACC, 8'h40, 4'h0, 6'h15);
      step(OP_PAGE_ZERO, 8'h00, 4'h0, 6'h15);
      step(OP_LOAD_ACC, 8'h40, 4'h0, 6'h34);
      step(OP_INC_MEM, 8'h40, 4'h0, 6'h34);
      step(OP_LOAD_ACC, 8'h40, 4'h0, 6'h38);
      step(OP_ROT_L_MEM_C, 8'h40, 4'h0, 6'h3A);
      step(OP_LOAD_ACC, 8'h40, 4'h0, 6'h32);
      step(OP_LIT_TO_REG, 8'h06, 4'hA, 6'h32);
      chk(21'(sfrWr), 21'h1);
      chk(21'(sfrWrAddr), 21'h06);
      chk(21'(sfrWrData), 21'hA);
      step(OP_REG_TO_RAM, 8'hFE, 4'h0, 6'h32);
      step(OP_LOAD_ACC, 8'h3E, 4'h0, 6'h2A);
      step(OP_LIT_TO_ACC, 8'h00, 4'h0, 6'h02);
      step(OP_PAGE_ONE, 8'h00, 4'h0, 6'h02);
      step(OP_LOAD_ACC, 8'h06, 4'h0, 6'h2A);
      step(OP_LOAD_ACC, 8'h3E, 4'h0, 6'h03);
      step(OP_BIT_SET, 8'hE5, 4'h1, 6'h03);
      for (int i = 0; i < 6; i++) begin
         step(OP_LIT_TO_REG, 8'(i), pv[i], 6'h03);
      end
      chk(21'(sfrWr), 21'h0);
      step(OP_LOAD_ACC, 8'h12, 4'h0, 6'h0A);
      step(OP_PAGE_ZERO, 8'h00, 4'h0, 6'h0A);
      step(OP_LOAD_ACC, 8'h12, 4'h0, 6'h0A);
      step(OP_LIT_TO_ACC, 8'h00, 4'h7, 6'h1E);
      step(OP_STORE_ACC, 8'h10, 4'h0, 6'h1E);
      chk(21'(bankSel), 21'h7);
      jp(OP_JUMP_BANK, 4'h0, 6'h1E, 1'b1, 21'h071234);
      chk(21'(pcPush), 21'h0);
      jp(OP_CALL_BANK, 4'h0, 6'h1E, 1'b1, 21'h071234);
      chk(21'(pcPush), 21'h1);
      jp(OP_JUMP_PTR, 4'h0, 6'h1E, 1'b1, 21'h154315);
      jp(OP_CALL_PTR, 4'h0, 6'h1E, 1'b1, 21'h154315);
      chk(21'(pcPush), 21'h1);
      step(OP_LIT_TO_ACC, 8'h00, 4'h0, 6'h02);
      step(OP_STORE_ACC, 8'h10, 4'h0, 6'h02);
      jumpAddr = 16'h000F;
      jp(OP_JUMP_BANK, 4'h0, 6'h02, 1'b1, 21'h00000F);
      chk(21'(reservedHit), 21'h1);
      jumpAddr = 16'h0400;
      jp(OP_JUMP_BANK, 4'h0, 6'h02, 1'b1, 21'h000400);
      chk(21'(reservedHit), 21'h0);
      step(OP_LIT_TO_ACC, 8'h00, 4'h3, 6'h0E);
      step(OP_STORE_ACC, 8'h11, 4'h0, 6'h0E);
      chk(21'(chanSel), 21'h3);
      sk(OP_SKIP_HEAD_ACTIVE, 4'h0, 6'h0E, 1'b1);
      sk(OP_SKIP_HEAD_IDLE, 4'h0, 6'h0E, 1'b0);
      sk(OP_SKIP_CHAN_IDLE, 4'h0, 6'h0E, 1'b1);
      sk(OP_SKIP_CHAN_ACTIVE, 4'h0, 6'h0E, 1'b0);
      sk(OP_SKIP_ALL_IDLE, 4'h0, 6'h0E, 1'b1);
      chanPlay = 8'hF7;
      sk(OP_SKIP_ALL_IDLE, 4'h0, 6'h0E, 1'b0);
      sk(OP_SKIP_CHAN_IDLE, 4'h0, 6'h0E, 1'b1);
      step(OP_LIT_TO_ACC, 8'h00, 4'h6, 6'h1A);
      sk(OP_SKIP_GT, 4'h5, 6'h1A, 1'b1);
      sk(OP_SKIP_GT, 4'h6, 6'h1A, 1'b0);
      sk(OP_SKIP_LT, 4'h7, 6'h1A, 1'b1);
      sk(OP_SKIP_LT, 4'h6, 6'h1A, 1'b0);
      sk(OP_SKIP_NE, 4'h6, 6'h1A, 1'b0);
      sk(OP_SKIP_NE, 4'h1, 6'h1A, 1'b1);
      sk(OP_SKIP_BIT_LOW, 4'h0, 6'h1A, 1'b1);
      sk(OP_SKIP_BIT_HIGH, 4'h2, 6'h1A, 1'b1);
      sk(OP_SKIP_BIT_HIGH, 4'h3, 6'h1A, 1'b0);
      step(OP_XOR_MEM, 8'h40, 4'h0, 6'h2A);
      step(OP_OR_MEM, 8'h07, 4'h0, 6'h2E);
      step(OP_AND_MEM, 8'h3E, 4'h0, 6'h2A);
      step(OP_ADD_MEM, 8'h40, 4'h0, 6'h1E);
      step(OP_SUB_MEM, 8'h40, 4'h0, 6'h2C);
      step(OP_DEC_MEM, 8'h40, 4'h0, 6'h2E);
      step(OP_ROT_R_MEM_C, 8'h40, 4'h0, 6'h2E);
      step(OP_LOAD_ACC, 8'h40, 4'h0, 6'h36);
      step(OP_BIT_CLEAR, 8'hFE, 4'h1, 6'h36);
      step(OP_RAM_TO_REG, 8'hFE, 4'h0, 6'h36);
      chk(21'(sfrWrAddr), 21'h06);
      chk(21'(sfrWrData), 21'h8);
      step(OP_LOAD_ACC, 8'h06, 4'h0, 6'h22);
      step(OP_STORE_ACC, 8'h12, 4'h0, 6'h22);
      step(OP_LIT_TO_ACC, 8'h00, 4'h0, 6'h02);
      step(OP_LOAD_ACC, 8'h12, 4'h0, 6'h22);
      opValid = 1'b0;
      end_sim();
   end
endmodule : tb
`default_nettype wire
